// *** hw/ppac_top.sv ***
// Register file, bus timing and control lines of the port adapter
`timescale 1ns/1ps

// Overview of operation
// - Select lines and access bit 2 choose data, direction or control.
// - Reset clears all registers; ports and secondary lines become inputs.
// - Direction bit 1 drives the matching port line, 0 leaves input.
// - Control bits 0-5 read/write; bits 6-7 read-only flags.
// - Control word: flags 7,6; secondary 5-3; access 2; primary 1-0.
// - Flags set only by active edges of input lines, never by writes.
// - Reading a section's data register clears both its flags.
// - Bit 0 lets the bit-7 flag pull the request low.
// - Bit 1 picks rising or falling edge for the primary input.
// - Pending bit-7 flag raises the request once bit 0 is written.
// - Bit 5 clear: secondary is input; bit 4 edge, bit 3 enable.
// - Pending bit-6 flag raises the request once bit 3 is written.
// - Mode 100: B line low after data write, high on flag set.
// - Mode 101: low after data write, high at the enable following a deselected one.
// - Mode 110: B secondary line held low.
// - Mode 111: B secondary line high; clearing bit 3 drives low.
// - Cleared flag rearms only after an enable with chip deselected.
// - Bit 5 set makes the secondary line an output.
module ppac_top (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic RESET_N,
  input wire logic ENABLE,
  input wire logic RW,
  input wire logic SELECT_POS_FIRST,
  input wire logic SELECT_POS_SECOND,
  input wire logic SELECT_NEG_N,
  input wire logic REG_SELECT_LOW,
  input wire logic REG_SELECT_HIGH,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  input wire logic [7:0] A_PORT_LINES_IN,
  output logic [7:0] A_PORT_LINES_OUT,
  output logic [7:0] A_PORT_LINES_OE,
  input wire logic [7:0] B_PORT_LINES_IN,
  output logic [7:0] B_PORT_LINES_OUT,
  output logic [7:0] B_PORT_LINES_OE,
  input wire logic A_PRIMARY_IRQ_INPUT,
  input wire logic B_PRIMARY_IRQ_INPUT,
  input wire logic A_SECONDARY_CTL_LINE_IN,
  output logic A_SECONDARY_CTL_LINE_OUT,
  output logic A_SECONDARY_CTL_LINE_OE,
  input wire logic B_SECONDARY_CTL_LINE_IN,
  output logic B_SECONDARY_CTL_LINE_OUT,
  output logic B_SECONDARY_CTL_LINE_OE,
  output logic A_IRQ_REQUEST_N,
  output logic B_IRQ_REQUEST_N
);
  logic [ppac_pkg::SY_W-1:0] async_in, f;
  logic clear, e_now, e_prev, next_e_prev, e_rise, e_fall;
  logic selected, rw, wr, rd, sec, sel_data, sel_dir, sel_ctl;
  logic [1:0] rs;
  logic [7:0] din, pins, rd_val;
  logic [7:0] port_data [2];
  logic [7:0] next_port_data [2];
  logic [7:0] port_dir [2];
  logic [7:0] next_port_dir [2];
  logic [ppac_pkg::CTL_W-1:0] ctl [2];
  logic [ppac_pkg::CTL_W-1:0] next_ctl [2];
  logic [7:0] data_out, next_data_out;
  logic data_oe, next_data_oe;
  logic [1:0] irq_n, next_irq_n, rd_clear;
  logic [3:0] flag, hit;
  logic pending, next_pending, desel_seen, next_desel_seen;
  logic b_sec, next_b_sec, b_sec_oe, next_b_sec_oe;
  logic a_sec, next_a_sec, a_sec_oe, next_a_sec_oe;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  assign async_in = {B_SECONDARY_CTL_LINE_IN, B_PRIMARY_IRQ_INPUT,
    A_SECONDARY_CTL_LINE_IN, A_PRIMARY_IRQ_INPUT, B_PORT_LINES_IN,
    A_PORT_LINES_IN, DATA_IN, REG_SELECT_HIGH, REG_SELECT_LOW,
    SELECT_NEG_N, SELECT_POS_SECOND, SELECT_POS_FIRST, RW, ENABLE,
    RESET_N};

  // Bus fields share one synchroniser so they stay aligned with enable
  ppac_sync #(.WIDTH(ppac_pkg::SY_W)) u_sync (
    .clock(CLOCK),
    .srst(SRST),
    .async_in(async_in),
    .filtered(f)
  );

  assign clear = SRST | ~f[ppac_pkg::SY_RSTN];
  assign e_now = f[ppac_pkg::SY_E];
  assign e_rise = e_now & ~e_prev;
  assign e_fall = ~e_now & e_prev;
  assign selected = f[ppac_pkg::SY_CS0] & f[ppac_pkg::SY_CS1] &
    ~f[ppac_pkg::SY_CS2N];
  assign rw = f[ppac_pkg::SY_RW];
  assign rs = f[ppac_pkg::SY_RS +: 2];
  assign din = f[ppac_pkg::SY_DATA +: 8];
  assign sec = rs[1];
  // Transfers take effect at the trailing edge of enable
  assign wr = e_fall & selected & ~rw;
  assign rd = e_fall & selected & rw;
  assign pins = sec ? f[ppac_pkg::SY_PB +: 8] : f[ppac_pkg::SY_PA +: 8];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // location select
  always_comb begin
    sel_data = 1'b0;
    sel_dir = 1'b0;
    sel_ctl = 1'b0;
    if (rs == ppac_pkg::SEL_A_DATA) begin
      sel_data = ctl[0][ppac_pkg::CTL_ACCESS];
      sel_dir = ~ctl[0][ppac_pkg::CTL_ACCESS];
    end else if (rs == ppac_pkg::SEL_A_CTRL) begin
      sel_ctl = 1'b1;
    end else if (rs == ppac_pkg::SEL_B_DATA) begin
      sel_data = ctl[1][ppac_pkg::CTL_ACCESS];
      sel_dir = ~ctl[1][ppac_pkg::CTL_ACCESS];
    end else begin
      sel_ctl = 1'b1;
    end
  end

  always_comb begin
    if (sel_ctl) begin
      rd_val = {flag[{sec, 1'b0}], flag[{sec, 1'b1}], ctl[sec]};
    end else if (sel_dir) begin
      rd_val = port_dir[sec];
    end else begin
      rd_val = (pins & ~port_dir[sec]) | (port_data[sec] & port_dir[sec]);
    end
  end

  assign rd_clear[0] = rd & sel_data & ~sec;
  assign rd_clear[1] = rd & sel_data & sec;

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  // Order: A primary, A secondary, B primary, B secondary
  for (genvar i = 0; i < 4; i++) begin : g_flag
    localparam int S = i / 2;
    localparam bit PRIMARY = (i % 2) == 0;
    ppac_flag u_flag (
      .clock(CLOCK),
      .clear(clear),
      .strobe(e_fall),
      .level(f[ppac_pkg::SY_CTL + i]),
      .rise_active(PRIMARY ? ctl[S][ppac_pkg::CTL_EDGE] :
        ctl[S][ppac_pkg::CTL_SEC_EDGE]),
      .listen(PRIMARY ? 1'b1 : ~ctl[S][ppac_pkg::CTL_SEC_OUT]),
      .read_clear(rd_clear[S]),
      .deselect(~selected),
      .flag(flag[i]),
      .hit(hit[i])
    );
  end

  // ----------------------------------------------------------------
  // Registers and control lines
  // ----------------------------------------------------------------
  always_comb begin
    next_e_prev = e_now;
    next_port_data = port_data;
    next_port_dir = port_dir;
    next_ctl = ctl;
    next_pending = pending;
    next_desel_seen = desel_seen;
    next_b_sec = b_sec;
    if (wr) begin
      if (sel_ctl) begin
        next_ctl[sec] = din[ppac_pkg::CTL_W-1:0];
      end else if (sel_dir) begin
        next_port_dir[sec] = din;
      end else begin
        next_port_data[sec] = din;
      end
    end
    // Bus is driven only while enable is high on a selected read
    next_data_oe = e_now & selected & rw;
    next_data_out = next_data_oe ? rd_val : data_out;
    for (int s = 0; s < 2; s++) begin
      next_irq_n[s] = ~((flag[2*s] & ctl[s][ppac_pkg::CTL_IRQ_EN]) |
        (flag[2*s+1] & ctl[s][ppac_pkg::CTL_SEC_EN] &
        ~ctl[s][ppac_pkg::CTL_SEC_OUT]));
    end
    if (wr && sel_data && sec) begin
      next_pending = 1'b1;
    end else if (e_rise) begin
      next_pending = 1'b0;
    end
    if (e_fall) begin
      next_desel_seen = ~selected;
    end
    next_b_sec_oe = ctl[1][ppac_pkg::CTL_SEC_OUT];
    next_a_sec_oe = ctl[0][ppac_pkg::CTL_SEC_OUT];
    // A output modes are limited to the manual levels; others idle high
    next_a_sec = ctl[0][ppac_pkg::CTL_SEC_EDGE] ?
      ctl[0][ppac_pkg::CTL_SEC_EN] : 1'b1;
    case (ctl[1][ppac_pkg::CTL_SEC_OUT:ppac_pkg::CTL_SEC_EN])
      ppac_pkg::SEC_HANDSHAKE: begin
        if (e_rise && pending) begin
          next_b_sec = 1'b0;
        end else if (hit[2]) begin
          next_b_sec = 1'b1;
        end
      end
      ppac_pkg::SEC_PULSE: begin
        if (e_rise && pending) begin
          next_b_sec = 1'b0;
        end else if (e_rise && desel_seen) begin
          next_b_sec = 1'b1;
        end
      end
      ppac_pkg::SEC_LOW: begin
        next_b_sec = 1'b0;
      end
      ppac_pkg::SEC_HIGH: begin
        next_b_sec = 1'b1;
      end
      default: begin
        next_b_sec = b_sec;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (clear) begin
      e_prev <= 1'b0;
      port_data <= '{ppac_pkg::REG_RESET, ppac_pkg::REG_RESET};
      port_dir <= '{ppac_pkg::REG_RESET, ppac_pkg::REG_RESET};
      ctl <= '{ppac_pkg::CTL_RESET, ppac_pkg::CTL_RESET};
      data_out <= ppac_pkg::REG_RESET;
      data_oe <= 1'b0;
      irq_n <= 2'h3;
      pending <= 1'b0;
      desel_seen <= 1'b0;
      b_sec <= 1'b0;
      b_sec_oe <= 1'b0;
      a_sec <= 1'b0;
      a_sec_oe <= 1'b0;
    end else begin
      e_prev <= next_e_prev;
      port_data <= next_port_data;
      port_dir <= next_port_dir;
      ctl <= next_ctl;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
      irq_n <= next_irq_n;
      pending <= next_pending;
      desel_seen <= next_desel_seen;
      b_sec <= next_b_sec;
      b_sec_oe <= next_b_sec_oe;
      a_sec <= next_a_sec;
      a_sec_oe <= next_a_sec_oe;
    end
  end

  assign DATA_OUT = data_out;
  assign DATA_OE = data_oe;
  assign A_PORT_LINES_OUT = port_data[0];
  assign A_PORT_LINES_OE = port_dir[0];
  assign B_PORT_LINES_OUT = port_data[1];
  assign B_PORT_LINES_OE = port_dir[1];
  assign A_SECONDARY_CTL_LINE_OUT = a_sec;
  assign A_SECONDARY_CTL_LINE_OE = a_sec_oe;
  assign B_SECONDARY_CTL_LINE_OUT = b_sec;
  assign B_SECONDARY_CTL_LINE_OE = b_sec_oe;
  assign A_IRQ_REQUEST_N = irq_n[0];
  assign B_IRQ_REQUEST_N = irq_n[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking dc @(posedge CLOCK);
  endclocking
  default disable iff (clear);

  ctl_write_a: assert property (
    wr && sel_ctl && !sec |=> ctl[0] == $past(din[5:0]))
    else $error("control A write not stored");

  reset_inputs_a: assert property (
    $fell(clear) |-> port_dir[0] == 8'h00 && port_dir[1] == 8'h00 &&
      !B_SECONDARY_CTL_LINE_OE && !A_SECONDARY_CTL_LINE_OE)
    else $error("lines not inputs after reset");

  dir_drive_a: assert property (
    wr && sel_dir && !sec |=> A_PORT_LINES_OE == $past(din))
    else $error("direction write did not reach port A");

  irq_enable_a: assert property (
    flag[0] && ctl[0][0] |=> !A_IRQ_REQUEST_N)
    else $error("enabled flag did not raise request A");

  irq_mask_a: assert property (
    !ctl[1][0] && !ctl[1][3] |=> B_IRQ_REQUEST_N)
    else $error("masked request B asserted");

  handshake_low_a: assert property (
    ctl[1][5:3] == 3'h4 && e_rise && pending |=> !B_SECONDARY_CTL_LINE_OUT)
    else $error("handshake line did not fall");

  pulse_high_a: assert property (
    ctl[1][5:3] == 3'h5 && e_rise && !pending && desel_seen
      |=> B_SECONDARY_CTL_LINE_OUT)
    else $error("pulse line did not return high");

  manual_level_a: assert property (
    ctl[1][5:4] == 2'h3 |=> B_SECONDARY_CTL_LINE_OUT == $past(ctl[1][3]))
    else $error("manual line level wrong");
endmodule // ppac_top

// *** hw/ppac_pkg.sv ***
// Shared constants of the parallel port adapter controls
package ppac_pkg;
  localparam int DATA_W = 8;
  // Register select codes
  localparam logic [1:0] SEL_A_DATA = 2'h0;
  localparam logic [1:0] SEL_A_CTRL = 2'h1;
  localparam logic [1:0] SEL_B_DATA = 2'h2;
  // Control word bit positions
  localparam int CTL_IRQ_EN = 0;
  localparam int CTL_EDGE = 1;
  localparam int CTL_ACCESS = 2;
  localparam int CTL_SEC_EN = 3;
  localparam int CTL_SEC_EDGE = 4;
  localparam int CTL_SEC_OUT = 5;
  localparam int CTL_W = 6;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [5:0] CTL_RESET = 6'h00;
  // Secondary line output modes, control bits 5..3
  localparam logic [2:0] SEC_HANDSHAKE = 3'h4;
  localparam logic [2:0] SEC_PULSE = 3'h5;
  localparam logic [2:0] SEC_LOW = 3'h6;
  localparam logic [2:0] SEC_HIGH = 3'h7;
  // Positions in the synchronised input vector
  localparam int SY_RSTN = 0;
  localparam int SY_E = 1;
  localparam int SY_RW = 2;
  localparam int SY_CS0 = 3;
  localparam int SY_CS1 = 4;
  localparam int SY_CS2N = 5;
  localparam int SY_RS = 6;
  localparam int SY_DATA = 8;
  localparam int SY_PA = 16;
  localparam int SY_PB = 24;
  localparam int SY_CTL = 32;
  localparam int SY_W = 36;
endpackage

// *** hw/ppac_sync.sv ***
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module ppac_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] filtered
);
  logic [WIDTH-1:0] s1, s2, s3, next_filtered;

  if (WIDTH < 1) begin : bad_width
    $error("ppac_sync needs WIDTH of at least one");
  end

  // A change counts only once stages two and three agree
  always_comb begin
    next_filtered = (filtered & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      filtered <= '0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      filtered <= next_filtered;
    end
  end

  sync_agree_a: assert property (
    @(posedge clock) disable iff (srst)
    1'b1 |=> ((filtered ^ $past(filtered)) & ($past(s2) ^ $past(s3))) == '0)
    else $error("filtered input changed while stages disagree");
endmodule // ppac_sync

// *** hw/ppac_flag.sv ***
// Edge-sensed interrupt flag of one control line
`timescale 1ns/1ps
module ppac_flag (
  input wire logic clock,
  input wire logic clear,
  input wire logic strobe,
  input wire logic level,
  input wire logic rise_active,
  input wire logic listen,
  input wire logic read_clear,
  input wire logic deselect,
  output logic flag,
  output logic hit
);
  logic last, armed, next_last, next_flag, next_armed;

  always_comb begin
    next_last = strobe ? level : last;
    hit = strobe & listen & armed &
      (rise_active ? (level & ~last) : (~level & last));
    next_flag = hit | (flag & ~read_clear);
    next_armed = armed;
    if (read_clear && !hit) begin
      next_armed = 1'b0;
    end else if (strobe && deselect) begin
      next_armed = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (clear) begin
      last <= 1'b0;
      flag <= 1'b0;
      armed <= 1'b0;
    end else begin
      last <= next_last;
      flag <= next_flag;
      armed <= next_armed;
    end
  end

  flag_cause_a: assert property (
    @(posedge clock) disable iff (clear)
    $rose(flag) |-> $past(strobe) && $past(listen) && $past(armed))
    else $error("flag set without an armed edge");

  flag_read_a: assert property (
    @(posedge clock) disable iff (clear)
    read_clear && !hit |=> !flag ##1 (!flag || $past(hit)))
    else $error("flag not cleared by data read");
endmodule // ppac_flag

// *** tb/ppac_host.sv ***
// Host bus master model issuing enable cycles to the port adapter
`timescale 1ns/1ps
module ppac_host (
  input wire logic clock,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic enable,
  output logic rw,
  output logic select_pos_first,
  output logic select_pos_second,
  output logic select_neg_n,
  output logic reg_select_low,
  output logic reg_select_high,
  output logic [7:0] data_in
);
  initial begin
    enable = 1'b0;
    rw = 1'b1;
    select_pos_first = 1'b0;
    select_pos_second = 1'b0;
    select_neg_n = 1'b1;
    reg_select_low = 1'b0;
    reg_select_high = 1'b0;
    data_in = 8'h00;
  end

  // ----------------------------------------
  // One enable cycle, selected or not
  // ----------------------------------------
  // selects held whole pulse
  task automatic cycle(input logic pick, input logic rd,
      input logic [1:0] sel, input logic [7:0] wdata,
      output logic [7:0] rdata);
    rdata = 'x;
    @(negedge clock);
    select_pos_first = pick;
    select_pos_second = pick;
    select_neg_n = !pick;
    rw = rd;
    reg_select_low = sel[0];
    reg_select_high = sel[1];
    // Released bus shows the inverse, never a stale copy
    data_in = rd ? ~data_in : wdata;
    // Margin covers the synchroniser latency before the pulse
    repeat (5) @(negedge clock);
    enable = 1'b1;
    repeat (10) begin
      @(negedge clock);
      if (data_oe === 1'b1)
        rdata = data_out;
    end
    enable = 1'b0;
    repeat (8) @(negedge clock);
    select_pos_first = 1'b0;
    select_pos_second = 1'b0;
    select_neg_n = 1'b1;
    data_in = ~data_in;
    repeat (2) @(negedge clock);
  endtask
endmodule // ppac_host

// *** tb/ppac_top_test.sv ***
// Self-checking bench of the port adapter controls
`timescale 1ns/1ps
module ppac_top_test;
  logic clock, srst, reset_n, enable, rw, cs_a, cs_b, cs_n, rs_lo, rs_hi;
  logic data_oe, a_pri, b_pri, a_sec_in, a_sec_out, a_sec_oe, a_sec_drv;
  logic b_sec_in, b_sec_out, b_sec_oe, b_sec_drv, a_irq_n, b_irq_n;
  logic [7:0] data_in, data_out, a_in, a_out, a_oe, a_pin;
  logic [7:0] b_in, b_out, b_oe, b_pin, got;
  logic [11:0] rows [14];
  int n_mismatch;
  int compares;

  // Wire levels from all drivers of each two-way line
  assign a_in = (a_pin & ~a_oe) | (a_out & a_oe);
  assign b_in = (b_pin & ~b_oe) | (b_out & b_oe);
  assign a_sec_in = (a_sec_oe === 1'b1) ? a_sec_out : a_sec_drv;
  assign b_sec_in = (b_sec_oe === 1'b1) ? b_sec_out : b_sec_drv;

  ppac_host ppac_host_inst (.clock(clock), .data_out(data_out),
    .data_oe(data_oe), .enable(enable), .rw(rw), .select_pos_first(cs_a),
    .select_pos_second(cs_b), .select_neg_n(cs_n),
    .reg_select_low(rs_lo), .reg_select_high(rs_hi), .data_in(data_in));

  ppac_top ppac_top_inst (.CLOCK(clock), .SRST(srst), .RESET_N(reset_n),
    .ENABLE(enable), .RW(rw), .SELECT_POS_FIRST(cs_a),
    .SELECT_POS_SECOND(cs_b), .SELECT_NEG_N(cs_n), .REG_SELECT_LOW(rs_lo),
    .REG_SELECT_HIGH(rs_hi), .DATA_IN(data_in), .DATA_OUT(data_out),
    .DATA_OE(data_oe), .A_PORT_LINES_IN(a_in), .A_PORT_LINES_OUT(a_out),
    .A_PORT_LINES_OE(a_oe), .B_PORT_LINES_IN(b_in),
    .B_PORT_LINES_OUT(b_out), .B_PORT_LINES_OE(b_oe),
    .A_PRIMARY_IRQ_INPUT(a_pri), .B_PRIMARY_IRQ_INPUT(b_pri),
    .A_SECONDARY_CTL_LINE_IN(a_sec_in), .A_SECONDARY_CTL_LINE_OUT(a_sec_out),
    .A_SECONDARY_CTL_LINE_OE(a_sec_oe), .B_SECONDARY_CTL_LINE_IN(b_sec_in),
    .B_SECONDARY_CTL_LINE_OUT(b_sec_out), .B_SECONDARY_CTL_LINE_OE(b_sec_oe),
    .A_IRQ_REQUEST_N(a_irq_n), .B_IRQ_REQUEST_N(b_irq_n));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] exp,
      input logic [7:0] seen);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] sel, input logic [7:0] val);
    logic [7:0] unused;
    ppac_host_inst.cycle(1'b1, 1'b0, sel, val, unused);
  endtask

  task automatic rd(input logic [1:0] sel, output logic [7:0] val);
    ppac_host_inst.cycle(1'b1, 1'b1, sel, 8'h00, val);
  endtask

  // Deselected pulse: rearms flags and conditions edge sensing
  task automatic desel;
    logic [7:0] unused;
    ppac_host_inst.cycle(1'b0, 1'b1, 2'h0, 8'h00, unused);
  endtask

  task automatic close_out;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    #(5000 * 40);
    n_mismatch++;
    close_out();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    reset_n = 1'b1;
    a_pin = 8'h3C;
    b_pin = 8'h96;
    a_pri = 1'b1;
    b_pri = 1'b1;
    a_sec_drv = 1'b1;
    b_sec_drv = 1'b1;
    n_mismatch = 0;
    compares = 0;
    // Nibble 0-3 writes, 4-7 reads; low two bits pick the location
    rows = '{12'h500, 12'h400, 12'h0F0, 12'h4F0, 12'h1C4, 12'h504, 12'h0A5,
      12'h4AC, 12'h700, 12'h20F, 12'h60F, 12'h304, 12'h25A, 12'h69A};
    repeat (2) @(negedge clock);
    srst = 1'b0;
    repeat (12) @(negedge clock);
    check("port enables", 8'h00, a_oe | b_oe);
    check("line state", 8'h03, {3'h0, data_oe, a_sec_oe, b_sec_oe,
      a_irq_n, b_irq_n});
    for (int i = 0; i < 14; i++) begin
      if (rows[i][10]) begin
        rd(rows[i][9:8], got);
        check("register readback", rows[i][7:0], got);
      end else begin
        wr(rows[i][9:8], rows[i][7:0]);
      end
    end
    check("a port", 8'hA5, a_out);
    check("a enables", 8'hF0, a_oe);
    check("b port", 8'h5A, b_out);
    check("b enables", 8'h0F, b_oe);
    // Primary A falling edge with request disabled, enabled later
    desel();
    a_pri = 1'b0;
    desel();
    rd(2'h1, got);
    check("a ctl flag", 8'h84, got);
    check("a irq off", 8'h01, {7'h0, a_irq_n});
    wr(2'h1, 8'h05);
    check("a irq late", 8'h00, {7'h0, a_irq_n});
    rd(2'h0, got);
    check("a irq cleared", 8'h01, {7'h0, a_irq_n});
    wr(2'h1, 8'h07);
    a_pri = 1'b1;
    rd(2'h1, got);
    check("a ctl unarmed", 8'h07, got);
    desel();
    a_pri = 1'b0;
    desel();
    a_pri = 1'b1;
    desel();
    check("a irq rising", 8'h00, {7'h0, a_irq_n});
    rd(2'h0, got);
    // Secondary A as falling-edge input
    wr(2'h1, 8'h04);
    desel();
    a_sec_drv = 1'b0;
    desel();
    rd(2'h1, got);
    check("a ctl sec flag", 8'h44, got);
    check("a sec input", 8'h01, {6'h0, a_sec_oe, a_irq_n});
    wr(2'h1, 8'h0C);
    check("a irq sec late", 8'h00, {7'h0, a_irq_n});
    rd(2'h0, got);
    // Secondary A as manual output, level follows bit 3
    wr(2'h1, 8'h3C);
    check("a sec manual high", 8'h03, {6'h0, a_sec_oe, a_sec_out});
    wr(2'h1, 8'h34);
    check("a sec manual low", 8'h02, {6'h0, a_sec_oe, a_sec_out});
    // Secondary B output modes
    wr(2'h3, 8'h34);
    check("b sec held low", 8'h02, {6'h0, b_sec_oe, b_sec_out});
    wr(2'h3, 8'h3C);
    check("b sec high", 8'h03, {6'h0, b_sec_oe, b_sec_out});
    wr(2'h3, 8'h34);
    check("b sec cleared", 8'h02, {6'h0, b_sec_oe, b_sec_out});
    wr(2'h3, 8'h3C);
    wr(2'h3, 8'h24);
    wr(2'h2, 8'h11);
    desel();
    check("b handshake low", 8'h02, {6'h0, b_sec_oe, b_sec_out});
    b_pri = 1'b0;
    desel();
    check("b handshake high", 8'h03, {6'h0, b_sec_oe, b_sec_out});
    rd(2'h2, got);
    wr(2'h3, 8'h2C);
    wr(2'h2, 8'h22);
    rd(2'h3, got);
    check("b ctl cleared", 8'h2C, got);
    check("b pulse low", 8'h02, {6'h0, b_sec_oe, b_sec_out});
    desel();
    check("b pulse waits", 8'h02, {6'h0, b_sec_oe, b_sec_out});
    desel();
    check("b pulse high", 8'h03, {6'h0, b_sec_oe, b_sec_out});
    // Device reset pin in mid-run
    reset_n = 1'b0;
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
    repeat (12) @(negedge clock);
    check("reset enables", 8'h00, a_oe | b_oe |
      {6'h0, a_sec_oe, b_sec_oe});
    rd(2'h3, got);
    check("reset b ctl", 8'h00, got);
    // Secondary B as rising-edge input with its request enabled
    wr(2'h3, 8'h1C);
    b_sec_drv = 1'b0;
    desel();
    b_sec_drv = 1'b1;
    desel();
    rd(2'h3, got);
    check("b ctl sec rising", 8'h5C, got);
    check("b irq sec", 8'h00, {7'h0, b_irq_n});
    close_out();
  end
endmodule // ppac_top_test
